// ==== hw/dsgate_defs.svh ====
// Offsets, bit positions, reset values and masks of the clock gating bank
`ifndef DSGATE_DEFS_SVH
`define DSGATE_DEFS_SVH

`define DSG_ADDR_W      12
`define DSG_NPERIPH     5

// Register byte offsets
`define DSG_RUN_OFF     12'h100
`define DSG_SLEEP_OFF   12'h110
`define DSG_DEEP_OFF    12'h120
`define DSG_CTRL_OFF    12'h140
`define DSG_ISTAT_OFF   12'h144
`define DSG_IMASK_OFF   12'h148

// Gate bit positions, shared by status and mask layouts
`define DSG_WDOG_BIT    5'h03
`define DSG_HIBER_BIT   5'h06
`define DSG_ADC_BIT     5'h10
`define DSG_PWM_BIT     5'h14
`define DSG_CAN_BIT     5'h18

// Peripheral index order: watchdog, hibernation, converter, PWM, CAN
`define DSG_IDX_WDOG    0
`define DSG_IDX_HIBER   1
`define DSG_IDX_ADC     2
`define DSG_IDX_PWM     3
`define DSG_IDX_CAN     4

`define DSG_GATE_WMASK  32'h01110048
`define DSG_GATE_RST    32'h00000040
`define DSG_AUTO_BIT    0
`define DSG_AUTO_RST    1'h0
`define DSG_IMASK_RST   5'h00
// Units that fault a bus access while unclocked: watchdog, converter, PWM
`define DSG_FAULTABLE   5'h0d

`endif

// ==== hw/dsgate_pkg.sv ====
// Types of the deep-sleep clock gating bank
`include "dsgate_defs.svh"

package dsgate_pkg;

  typedef struct packed {
    logic                    psel;
    logic                    penable;
    logic                    pwrite;
    logic [`DSG_ADDR_W-1:0]  paddr;
    logic [31:0]             pwdata;
  } apb_req_t;

  typedef struct packed {
    logic                    pready;
    logic                    pslverr;
    logic [31:0]             prdata;
  } apb_rsp_t;

  typedef struct packed {
    logic [31:0]             run_gate;
    logic [31:0]             sleep_gate;
    logic [31:0]             deep_gate;
    logic                    auto_gate;
    logic [`DSG_NPERIPH-1:0] int_status;
    logic [`DSG_NPERIPH-1:0] int_mask;
    logic [`DSG_NPERIPH-1:0] clk_en;
    logic [`DSG_NPERIPH-1:0] fault;
    logic                    irq;
    apb_rsp_t                rsp;
  } state_t;

endpackage

// ==== hw/gate_fault_check.sv ====
// Flags accesses aimed at peripherals whose clock is gated off
`timescale 1ns/1ps
`include "dsgate_defs.svh"

module gate_fault_check #(
  parameter int unsigned     N         = `DSG_NPERIPH,
  parameter logic [N-1:0]    FAULTABLE = `DSG_FAULTABLE
) (
  input  wire logic [N-1:0]  access_i,
  input  wire logic [N-1:0]  clk_en_i,
  output logic [N-1:0]       fault_o
);

  // Units not marked faultable keep a silent access while unclocked
  assign fault_o = access_i & ~clk_en_i & FAULTABLE; // [R2]

endmodule // gate_fault_check

// ==== hw/deep_sleep_clock_gating_bank.sv ====
// Run, sleep and deep-sleep peripheral clock gating bank with APB access
//
// Notes on behaviour
// R1: Each gate bit enables one peripheral clock
// R2: Access to gated unit raises bus fault; only watchdog, converter and PWM fault here, CAN never does
// R3: Gates reset cleared; register resets to 0x40
// R4: Software enables the peripherals it needs
// R5: Separate run, sleep and deep-sleep gate registers
// R6: Auto gating bit selects sleep-mode registers
// R7: Bit 6 gates hibernation, resets one, no fault
// R8: Bit 3 gates watchdog, faults when gated
// R9: Bit 16 gates converter, faults when gated
// R10: Reserved bits read zero, ignore writes
// R11: Bit 24 gates CAN unit zero
// R12: Bit 20 gates PWM, faults when gated
// R13: Deep-sleep gates apply only in auto deep sleep
`timescale 1ns/1ps
`include "dsgate_defs.svh"

module deep_sleep_clock_gating_bank #(
  parameter int unsigned N = `DSG_NPERIPH
) (
  input  wire logic                clock_i,
  input  wire logic                rst_i,
  input  wire dsgate_pkg::apb_req_t apb_i,
  output dsgate_pkg::apb_rsp_t     apb_o,
  input  wire logic                sleep_i,
  input  wire logic                deep_sleep_i,
  input  wire logic [N-1:0]        periph_access_i,
  output logic [N-1:0]             periph_clk_en_o,
  output logic [N-1:0]             periph_fault_o,
  output logic                     irq_o
);

  localparam logic [N*5-1:0] POS = {`DSG_CAN_BIT, `DSG_PWM_BIT,
                                    `DSG_ADC_BIT, `DSG_HIBER_BIT,
                                    `DSG_WDOG_BIT};

  localparam dsgate_pkg::state_t ST_RST = '{
    run_gate:   `DSG_GATE_RST,
    sleep_gate: `DSG_GATE_RST,
    deep_gate:  `DSG_GATE_RST, // [R3] [R7]
    auto_gate:  `DSG_AUTO_RST,
    int_status: '0,
    int_mask:   `DSG_IMASK_RST,
    clk_en:     '0,
    fault:      '0,
    irq:        1'h0,
    rsp:        '0
  };

  dsgate_pkg::state_t st_q;
  dsgate_pkg::state_t st_d;

  logic [N-1:0]  run_bits;
  logic [N-1:0]  sleep_bits;
  logic [N-1:0]  deep_bits;
  logic [N-1:0]  pw_bits;
  logic [N-1:0]  rd_stat_bits;
  logic [N-1:0]  sel_bits;
  logic [N-1:0]  fault_now;
  logic [31:0]   istat_word;
  logic [31:0]   imask_word;
  logic          setup_ph;
  logic          done_ph;
  logic          hit;

  // Gather gate bits to peripheral index, scatter status to bit layout
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_map
      assign run_bits[gi]     = st_q.run_gate[POS[gi*5 +: 5]];
      assign sleep_bits[gi]   = st_q.sleep_gate[POS[gi*5 +: 5]];
      assign deep_bits[gi]    = st_q.deep_gate[POS[gi*5 +: 5]];
      assign pw_bits[gi]      = apb_i.pwdata[POS[gi*5 +: 5]];
      assign rd_stat_bits[gi] = st_q.rsp.prdata[POS[gi*5 +: 5]];
    end
  endgenerate

  always_comb begin
    istat_word = '0;
    imask_word = '0;
    for (int i = 0; i < N; i++) begin
      istat_word[POS[i*5 +: 5]] = st_q.int_status[i];
      imask_word[POS[i*5 +: 5]] = st_q.int_mask[i];
    end
  end

  // Mode selection of the applied gate set
  always_comb begin
    if (st_q.auto_gate && deep_sleep_i) begin
      sel_bits = deep_bits; // [R13] [R5]
    end else if (st_q.auto_gate && sleep_i) begin
      sel_bits = sleep_bits; // [R6]
    end else begin
      sel_bits = run_bits; // [R13]
    end
  end

  gate_fault_check #(
    .N         (N),
    .FAULTABLE (`DSG_FAULTABLE)
  ) u_fault (
    .access_i  (periph_access_i),
    .clk_en_i  (st_q.clk_en),
    .fault_o   (fault_now)
  );

  assign setup_ph = apb_i.psel && apb_i.penable && !st_q.rsp.pready;
  assign done_ph  = apb_i.psel && apb_i.penable && st_q.rsp.pready;

  always_comb begin
    hit = 1'b1;
    case (apb_i.paddr)
      `DSG_RUN_OFF,
      `DSG_SLEEP_OFF,
      `DSG_DEEP_OFF,
      `DSG_CTRL_OFF,
      `DSG_ISTAT_OFF,
      `DSG_IMASK_OFF: hit = 1'b1;
      default:        hit = 1'b0;
    endcase
  end

  always_comb begin
    st_d             = st_q;
    st_d.fault       = fault_now; // [R2] [R8] [R9] [R12]
    st_d.clk_en      = sel_bits; // [R1] [R11]
    st_d.rsp.pready  = setup_ph;
    st_d.rsp.pslverr = 1'b0;
    if (setup_ph) begin
      st_d.rsp.pslverr = !hit;
      // Reserved bits read zero, stored bits already masked
      case (apb_i.paddr)
        `DSG_RUN_OFF:   st_d.rsp.prdata = st_q.run_gate;
        `DSG_SLEEP_OFF: st_d.rsp.prdata = st_q.sleep_gate;
        `DSG_DEEP_OFF:  st_d.rsp.prdata = st_q.deep_gate; // [R10]
        `DSG_CTRL_OFF:  st_d.rsp.prdata = {31'h0, st_q.auto_gate};
        `DSG_ISTAT_OFF: st_d.rsp.prdata = istat_word;
        `DSG_IMASK_OFF: st_d.rsp.prdata = imask_word;
        default:        st_d.rsp.prdata = 32'h0;
      endcase
    end else if (done_ph) begin
      st_d.rsp.prdata = st_q.rsp.prdata;
    end else begin
      st_d.rsp.prdata = 32'h0;
    end
    if (done_ph && apb_i.pwrite) begin
      case (apb_i.paddr)
        `DSG_RUN_OFF:
          st_d.run_gate = apb_i.pwdata & `DSG_GATE_WMASK;
        `DSG_SLEEP_OFF:
          st_d.sleep_gate = apb_i.pwdata & `DSG_GATE_WMASK;
        `DSG_DEEP_OFF:
          st_d.deep_gate = apb_i.pwdata & `DSG_GATE_WMASK; // [R10]
        `DSG_CTRL_OFF:
          st_d.auto_gate = apb_i.pwdata[`DSG_AUTO_BIT];
        `DSG_IMASK_OFF:
          st_d.int_mask = pw_bits;
        default: st_d.run_gate = st_q.run_gate;
      endcase
    end
    // Read clears only what was returned; a new event still sets
    if (done_ph && !apb_i.pwrite && apb_i.paddr == `DSG_ISTAT_OFF) begin
      st_d.int_status = st_q.int_status & ~rd_stat_bits;
    end
    st_d.int_status = st_d.int_status | fault_now;
    st_d.irq        = |(st_d.int_status & st_d.int_mask);
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st_q <= ST_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign apb_o           = st_q.rsp;
  assign periph_clk_en_o = st_q.clk_en;
  assign periph_fault_o  = st_q.fault;
  assign irq_o           = st_q.irq;

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking

  AST_RESET_VALUE: assert property ( // [R3]
    $past(rst_i) && !rst_i |->
      st_q.deep_gate == `DSG_GATE_RST && st_q.clk_en == '0)
    else $error("gate register not at reset value after reset");

  AST_DEEP_APPLIED: assert property ( // [R5]
    disable iff (rst_i)
    st_q.auto_gate && deep_sleep_i |=>
      periph_clk_en_o == $past(deep_bits))
    else $error("deep-sleep gates not applied in deep sleep");

  AST_SLEEP_APPLIED: assert property ( // [R6]
    disable iff (rst_i)
    st_q.auto_gate && sleep_i && !deep_sleep_i |=>
      periph_clk_en_o == $past(sleep_bits))
    else $error("sleep gates not applied in sleep");

  AST_RUN_APPLIED: assert property ( // [R13]
    disable iff (rst_i)
    !st_q.auto_gate |=> periph_clk_en_o == $past(run_bits))
    else $error("run gates not applied without auto gating");

  AST_GATED_FAULT: assert property ( // [R2]
    disable iff (rst_i)
    |(periph_access_i & ~periph_clk_en_o & `DSG_FAULTABLE) |=>
      |periph_fault_o && irq_o == |(st_q.int_status & st_q.int_mask))
    else $error("access to gated unit did not fault");

  AST_NO_SILENT_FAULT: assert property ( // [R7]
    disable iff (rst_i)
    ##1 !periph_fault_o[`DSG_IDX_HIBER] && !periph_fault_o[`DSG_IDX_CAN])
    else $error("hibernation or CAN unit faulted");

  AST_DEEP_WRITE: assert property ( // [R8]
    disable iff (rst_i)
    done_ph && apb_i.pwrite && apb_i.paddr == `DSG_DEEP_OFF |=>
      st_q.deep_gate == ($past(apb_i.pwdata) & `DSG_GATE_WMASK))
    else $error("deep-sleep gate write not stored");

  AST_RESERVED_ZERO: assert property ( // [R10]
    disable iff (rst_i)
    apb_o.pready && !apb_o.pslverr && $past(apb_i.paddr) == `DSG_DEEP_OFF
      |-> (apb_o.prdata & ~`DSG_GATE_WMASK) == 32'h0)
    else $error("reserved gate bits read nonzero");

  AST_WRITE_TO_CLOCK: assert property ( // [R9]
    disable iff (rst_i)
    done_ph && apb_i.pwrite && apb_i.paddr == `DSG_RUN_OFF &&
      !st_q.auto_gate && !rst_i ##1 !st_q.auto_gate |=>
      periph_clk_en_o[2] == $past(st_q.run_gate[`DSG_ADC_BIT]))
    else $error("converter clock enable does not follow write");

  AST_ONE_WAIT: assert property ( // [R12]
    disable iff (rst_i)
    apb_i.psel && !apb_i.penable ##1 apb_i.psel && apb_i.penable
      |=> apb_o.pready)
    else $error("APB answer not after one wait state");

  AST_AUTO_IDLE_RUN: assert property ( // [R6]
    disable iff (rst_i)
    st_q.auto_gate && !sleep_i && !deep_sleep_i |=>
      periph_clk_en_o == $past(run_bits))
    else $error("run gates not applied outside sleep");

  AST_STATUS_STICKY: assert property ( // [R2]
    disable iff (rst_i)
    !(done_ph && !apb_i.pwrite && apb_i.paddr == `DSG_ISTAT_OFF) |=>
      (st_q.int_status & $past(st_q.int_status)) == $past(st_q.int_status))
    else $error("interrupt status bit lost without a read");

  AST_IRQ_LEVEL: assert property ( // [R2]
    disable iff (rst_i)
    irq_o == |(st_q.int_status & st_q.int_mask))
    else $error("interrupt line differs from masked status");

  AST_FAULT_NEEDS_ACCESS: assert property ( // [R2]
    disable iff (rst_i)
    ##1 (periph_fault_o & ~$past(periph_access_i)) == '0)
    else $error("fault raised without an access");

  AST_READ_CLEAR: assert property ( // [R2]
    disable iff (rst_i)
    done_ph && !apb_i.pwrite && apb_i.paddr == `DSG_ISTAT_OFF |=>
      (st_q.int_status & $past(rd_stat_bits & ~fault_now)) == '0)
    else $error("returned status bits not cleared by read");

  AST_SLVERR_ZERO: assert property ( // [R10]
    disable iff (rst_i)
    apb_o.pready && apb_o.pslverr |-> apb_o.prdata == 32'h0)
    else $error("unmapped read returned data");

  AST_GATES_RESERVED: assert property ( // [R10]
    disable iff (rst_i)
    ((st_q.run_gate | st_q.sleep_gate | st_q.deep_gate) &
      ~`DSG_GATE_WMASK) == 32'h0)
    else $error("reserved gate bit stored");

  AST_CAN_CLOCK: assert property ( // [R11]
    disable iff (rst_i)
    st_q.auto_gate && deep_sleep_i |=>
      periph_clk_en_o[`DSG_IDX_CAN] == $past(st_q.deep_gate[`DSG_CAN_BIT]))
    else $error("CAN unit clock does not follow its gate bit");

  AST_WDOG_FAULT: assert property ( // [R8]
    disable iff (rst_i)
    periph_access_i[`DSG_IDX_WDOG] && !periph_clk_en_o[`DSG_IDX_WDOG] |=>
      periph_fault_o[`DSG_IDX_WDOG])
    else $error("watchdog access while gated did not fault");

  AST_ADC_FAULT: assert property ( // [R9]
    disable iff (rst_i)
    periph_access_i[`DSG_IDX_ADC] && !periph_clk_en_o[`DSG_IDX_ADC] |=>
      periph_fault_o[`DSG_IDX_ADC])
    else $error("converter access while gated did not fault");

  AST_PWM_FAULT: assert property ( // [R12]
    disable iff (rst_i)
    periph_access_i[`DSG_IDX_PWM] && !periph_clk_en_o[`DSG_IDX_PWM] |=>
      periph_fault_o[`DSG_IDX_PWM])
    else $error("PWM access while gated did not fault");

endmodule // deep_sleep_clock_gating_bank

// ==== test/deep_sleep_clock_gating_bank_tb.sv ====
// Directed testbench for the deep-sleep clock gating bank
`timescale 1ns/1ps
`include "dsgate_defs.svh"

module deep_sleep_clock_gating_bank_tb;
  logic                 clock_i;
  logic                 rst_i;
  dsgate_pkg::apb_req_t apb_i;
  dsgate_pkg::apb_rsp_t apb_o;
  logic                 sleep_i;
  logic                 deep_sleep_i;
  logic [4:0]           periph_access_i;
  logic [4:0]           periph_clk_en_o;
  logic [4:0]           periph_fault_o;
  logic                 irq_o;
  int                   n_mismatch;
  int                   comparisons;
  int                   cycles = 0;
  logic [31:0]          rd;
  logic                 er;

  deep_sleep_clock_gating_bank #(
    .N (`DSG_NPERIPH)
  ) u_deep_sleep_clock_gating_bank (
    .clock_i         (clock_i),
    .rst_i           (rst_i),
    .apb_i           (apb_i),
    .apb_o           (apb_o),
    .sleep_i         (sleep_i),
    .deep_sleep_i    (deep_sleep_i),
    .periph_access_i (periph_access_i),
    .periph_clk_en_o (periph_clk_en_o),
    .periph_fault_o  (periph_fault_o),
    .irq_o           (irq_o)
  );

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge clock_i);
    apb_i.psel    <= 1'b1;
    apb_i.penable <= 1'b0;
    apb_i.pwrite  <= w;
    apb_i.paddr   <= a;
    apb_i.pwdata  <= d;
    @(posedge clock_i);
    apb_i.penable <= 1'b1;
    do begin
      @(posedge clock_i);
    end while (apb_o.pready !== 1'b1);
    rd = apb_o.prdata;
    er = apb_o.pslverr;
    apb_i.psel    <= 1'b0;
    apb_i.penable <= 1'b0;
  endtask

  task automatic mode(input logic s, input logic d);
    @(posedge clock_i);
    sleep_i      <= s;
    deep_sleep_i <= d;
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  task automatic poke(input logic [4:0] acc);
    @(posedge clock_i);
    periph_access_i <= acc;
    @(posedge clock_i);
    periph_access_i <= 5'h00;
    #1;
  endtask

  task automatic settle();
    repeat (3) @(posedge clock_i);
    #1;
  endtask

  initial begin
    rst_i           = 1'b1;
    sleep_i         = 1'b0;
    deep_sleep_i    = 1'b0;
    periph_access_i = 5'h00;
    apb_i           = '0;
    n_mismatch      = 0;
    comparisons     = 0;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    settle();
    // Only the hibernation clock runs after reset
    chk({27'h0, periph_clk_en_o}, 32'h00000002);
    apb(1'b0, `DSG_DEEP_OFF, 32'h0);
    chk(rd, 32'h00000040);
    apb(1'b1, `DSG_DEEP_OFF, 32'hffffffff);
    apb(1'b0, `DSG_DEEP_OFF, 32'h0);
    chk(rd, 32'h01110048);
    apb(1'b0, 12'hffc, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk(rd, 32'h0);
    // All run gates off, so every unit is unclocked
    apb(1'b1, `DSG_RUN_OFF, 32'h0);
    settle();
    chk({27'h0, periph_clk_en_o}, 32'h0);
    poke(5'h1f);
    chk({27'h0, periph_fault_o}, 32'h0000000d);
    settle();
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b1, `DSG_IMASK_OFF, 32'h01110048);
    settle();
    chk({31'h0, irq_o}, 32'h1);
    apb(1'b0, `DSG_ISTAT_OFF, 32'h0);
    chk(rd, 32'h00110008);
    settle();
    chk({31'h0, irq_o}, 32'h0);
    apb(1'b0, `DSG_ISTAT_OFF, 32'h0);
    chk(rd, 32'h0);
    // Automatic gating: deep sleep, then sleep, then both inputs, then disabled
    apb(1'b1, `DSG_CTRL_OFF, 32'h1);
    mode(1'b0, 1'b1);
    chk({27'h0, periph_clk_en_o}, 32'h0000001f);
    poke(5'h1f);
    chk({27'h0, periph_fault_o}, 32'h0);
    mode(1'b1, 1'b0);
    chk({27'h0, periph_clk_en_o}, 32'h00000002);
    mode(1'b1, 1'b1);
    chk({27'h0, periph_clk_en_o}, 32'h0000001f);
    apb(1'b1, `DSG_CTRL_OFF, 32'h0);
    settle();
    chk({27'h0, periph_clk_en_o}, 32'h0);
    // Sleep set with reserved bits written, then readback of the rest
    apb(1'b1, `DSG_SLEEP_OFF, 32'h81000808);
    apb(1'b0, `DSG_SLEEP_OFF, 32'h0);
    chk(rd, 32'h01000008);
    apb(1'b0, `DSG_RUN_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, `DSG_IMASK_OFF, 32'h0);
    chk(rd, 32'h01110048);
    apb(1'b1, `DSG_CTRL_OFF, 32'h1);
    apb(1'b0, `DSG_CTRL_OFF, 32'h0);
    chk(rd, 32'h1);
    mode(1'b1, 1'b0);
    chk({27'h0, periph_clk_en_o}, 32'h00000011);
    poke(5'h1f);
    chk({27'h0, periph_fault_o}, 32'h0000000c);
    settle();
    chk({31'h0, irq_o}, 32'h1);
    apb(1'b0, `DSG_ISTAT_OFF, 32'h0);
    chk(rd, 32'h00110000);
    // Automatic gating outside sleep keeps the run set
    mode(1'b0, 1'b0);
    chk({27'h0, periph_clk_en_o}, 32'h0);
    // Reset in mid-run brings back the reset values
    @(posedge clock_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    settle();
    chk({27'h0, periph_clk_en_o}, 32'h00000002);
    apb(1'b0, `DSG_DEEP_OFF, 32'h0);
    chk(rd, 32'h00000040);
    apb(1'b0, `DSG_CTRL_OFF, 32'h0);
    chk(rd, 32'h0);
    report_and_stop();
  end
endmodule // deep_sleep_clock_gating_bank_tb
